// *** hw/tmw_pkg.sv ***
`default_nettype none
package tmw_pkg;
   localparam logic [2:0] TMW_CS_STOP      = 3'h0;
   localparam logic [2:0] TMW_CS_EXT_FALL  = 3'h6;
   localparam logic [2:0] TMW_CS_EXT_RISE  = 3'h7;
   localparam logic [7:0] TMW_BOTTOM       = 8'h00;
   localparam logic [7:0] TMW_MAX          = 8'hFF;
   localparam logic [7:0] TMW_COUNT_RESET  = 8'h00;
   localparam logic [7:0] TMW_CMP_RESET    = 8'h00;
   localparam int         TMW_DIV_W        = 10;
   localparam logic [9:0] TMW_DIV_8        = 10'h007;
   localparam logic [9:0] TMW_DIV_64       = 10'h03F;
   localparam logic [9:0] TMW_DIV_256      = 10'h0FF;
   localparam logic [9:0] TMW_DIV_1024     = 10'h3FF;

   typedef enum logic [2:0] {
      TMW_MODE_NORMAL   = 3'b000,
      TMW_MODE_PC_MAX   = 3'b001,
      TMW_MODE_CTC      = 3'b010,
      TMW_MODE_FAST_MAX = 3'b011,
      TMW_MODE_RSV4     = 3'b100,
      TMW_MODE_PC_OCA   = 3'b101,
      TMW_MODE_RSV6     = 3'b110,
      TMW_MODE_FAST_OCA = 3'b111
   } tmw_mode_e;

   localparam logic [1:0] TMW_COM_NONE   = 2'h0;
   localparam logic [1:0] TMW_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TMW_COM_CLEAR  = 2'h2;
   localparam logic [1:0] TMW_COM_SET    = 2'h3;
endpackage
`default_nettype wire

// *** hw/tmw_tick_select.sv ***
`default_nettype none
module tmw_tick_select
   import tmw_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [2:0] tick_source_select,
   input  wire logic       ext_tick_pin,
   output logic            timer_tick
);
   typedef struct packed {
      logic [TMW_DIV_W-1:0] div;
      logic                 ext_prev;
   } tmw_tick_s;

   tmw_tick_s st;
   tmw_tick_s next_st;

   function automatic logic div_hit(input logic [9:0] cnt, input logic [9:0] mask);
      div_hit = ((cnt & mask) == mask);
   endfunction

   always_comb begin
      next_st          = st;
      next_st.div      = st.div + 10'h001;
      next_st.ext_prev = ext_tick_pin;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // zero select gates every tick off
   always_comb begin
      unique case (tick_source_select)
         TMW_CS_STOP:     timer_tick = 1'b0;
         3'h1:            timer_tick = 1'b1;
         3'h2:            timer_tick = div_hit(st.div, TMW_DIV_8);
         3'h3:            timer_tick = div_hit(st.div, TMW_DIV_64);
         3'h4:            timer_tick = div_hit(st.div, TMW_DIV_256);
         3'h5:            timer_tick = div_hit(st.div, TMW_DIV_1024);
         TMW_CS_EXT_FALL: timer_tick = st.ext_prev & ~ext_tick_pin;
         TMW_CS_EXT_RISE: timer_tick = ~st.ext_prev & ext_tick_pin;
      endcase
   end
endmodule
`default_nettype wire

// *** hw/tmw_timer8.sv ***
`default_nettype none
module tmw_timer8
   import tmw_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [2:0] tick_source_select,
   input  wire logic       ext_tick_pin,
   input  wire logic [1:0] wave_mode_ctl_a,
   input  wire logic       wave_mode_bit2,
   input  wire logic [1:0] output_action_bits_a,
   input  wire logic [1:0] output_action_bits_b,
   input  wire logic       force_compare_strobe_a,
   input  wire logic       force_compare_strobe_b,
   input  wire logic       count_wr,
   input  wire logic [7:0] count_wdata,
   input  wire logic       cmp_a_wr,
   input  wire logic       cmp_b_wr,
   input  wire logic [7:0] cmp_wdata,
   input  wire logic [2:0] flag_clear_wr,
   input  wire logic [2:0] int_serviced,
   input  wire logic [2:0] int_mask,
   input  wire logic       port_out_a,
   input  wire logic       port_out_b,
   input  wire logic       pin_direction_bit_a,
   input  wire logic       pin_direction_bit_b,
   output logic [7:0]      count_value,
   output logic [7:0]      compare_value_a,
   output logic [7:0]      compare_value_b,
   output logic            overflow_flag,
   output logic            match_flag_a,
   output logic            match_flag_b,
   output logic [2:0]      int_req,
   output logic            wave_out_a,
   output logic            wave_out_a_oe,
   output logic            wave_out_b,
   output logic            wave_out_b_oe
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       down;
      logic [7:0] ocr_a;
      logic [7:0] ocr_b;
      logic [7:0] buf_a;
      logic [7:0] buf_b;
      logic       block;
      logic       pend_a;
      logic       pend_b;
      logic       tov;
      logic       ocf_a;
      logic       ocf_b;
      logic       oc_a;
      logic       oc_b;
   } tmw_state_s;

   tmw_state_s st;
   tmw_state_s next_st;
   logic       rst_n;
   logic       timer_tick;
   tmw_mode_e  mode;
   logic       is_pwm;
   logic       is_fast;
   logic       is_pc;
   logic [7:0] top_val;
   logic       at_top;
   logic       at_bottom;
   logic       match_a;
   logic       match_b;
   logic       hit_a;
   logic       hit_b;
   logic [1:0] rst_sync;

   // released through two flops; rest of block sees the synced copy
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   tmw_tick_select u_tick (
      .mclk               (mclk),
      .rst_n              (rst_n),
      .tick_source_select (tick_source_select),
      .ext_tick_pin       (ext_tick_pin),
      .timer_tick         (timer_tick)
   );

   assign mode    = tmw_mode_e'({wave_mode_bit2, wave_mode_ctl_a});
   assign is_fast = (mode == TMW_MODE_FAST_MAX) || (mode == TMW_MODE_FAST_OCA);
   assign is_pc   = (mode == TMW_MODE_PC_MAX) || (mode == TMW_MODE_PC_OCA);
   assign is_pwm  = is_fast | is_pc;
   assign top_val = (mode == TMW_MODE_CTC || mode == TMW_MODE_PC_OCA || mode == TMW_MODE_FAST_OCA)
                    ? st.ocr_a : TMW_MAX;
   assign at_top    = (st.cnt == top_val);
   assign at_bottom = (st.cnt == TMW_BOTTOM);
   assign match_a   = (st.cnt == st.ocr_a);
   assign match_b   = (st.cnt == st.ocr_b);
   // a match seen earlier in the tick period, or in the very cycle of the tick
   assign hit_a     = st.pend_a | (match_a & ~st.block);
   assign hit_b     = st.pend_b | (match_b & ~st.block);

   // next output state for a match in the current mode and direction
   function automatic logic oc_on_match(input logic cur, input logic [1:0] com,
                                        input logic pwm, input logic down);
      unique case (com)
         TMW_COM_NONE:   oc_on_match = cur;
         TMW_COM_TOGGLE: oc_on_match = pwm ? cur : ~cur;
         TMW_COM_CLEAR:  oc_on_match = pwm ? down : 1'b0;
         TMW_COM_SET:    oc_on_match = pwm ? ~down : 1'b1;
      endcase
   endfunction

   function automatic logic oc_at_bottom(input logic cur, input logic [1:0] com);
      unique case (com)
         TMW_COM_CLEAR: oc_at_bottom = 1'b1;
         TMW_COM_SET:   oc_at_bottom = 1'b0;
         default:       oc_at_bottom = cur;
      endcase
   endfunction

   always_comb begin
      next_st = st;
      // flags rebuilt from this cycle's set events plus surviving old values
      next_st.tov   = 1'b0;
      next_st.ocf_a = 1'b0;
      next_st.ocf_b = 1'b0;
      // a match seen in one tick period takes effect at the next tick
      if (match_a && !st.block) begin
         next_st.pend_a = 1'b1;
      end
      if (match_b && !st.block) begin
         next_st.pend_b = 1'b1;
      end
      if (timer_tick) begin
         next_st.pend_a = 1'b0;
         next_st.pend_b = 1'b0;
         next_st.block  = 1'b0;
         if (hit_a) begin
            next_st.ocf_a = 1'b1;
            next_st.oc_a  = oc_on_match(st.oc_a, output_action_bits_a, is_pwm, st.down);
         end
         if (hit_b) begin
            next_st.ocf_b = 1'b1;
            next_st.oc_b  = oc_on_match(st.oc_b, output_action_bits_b, is_pwm, st.down);
         end
         if (is_pc) begin
            if (at_top) begin
               next_st.down = 1'b1;
               next_st.cnt  = st.cnt - 8'h01;
            end else if (st.down && at_bottom) begin
               next_st.down = 1'b0;
               next_st.cnt  = st.cnt + 8'h01;
            end else begin
               next_st.cnt = st.down ? st.cnt - 8'h01 : st.cnt + 8'h01;
            end
            if (at_top) begin
               next_st.ocr_a = st.buf_a;
               next_st.ocr_b = st.buf_b;
            end
            if (st.down && st.cnt == 8'h01) begin
               next_st.tov = 1'b1;
            end
         end else if (is_fast) begin
            next_st.down = 1'b0;
            if (at_top) begin
               next_st.cnt   = TMW_BOTTOM;
               next_st.tov   = 1'b1;
               next_st.ocr_a = st.buf_a;
               next_st.ocr_b = st.buf_b;
               next_st.oc_a  = oc_at_bottom(st.oc_a, output_action_bits_a);
               next_st.oc_b  = oc_at_bottom(st.oc_b, output_action_bits_b);
            end else begin
               next_st.cnt = st.cnt + 8'h01;
            end
         end else begin
            next_st.down = 1'b0;
            if (mode == TMW_MODE_CTC && hit_a) begin
               next_st.cnt = TMW_BOTTOM;
            end else begin
               next_st.cnt = st.cnt + 8'h01;
            end
            if (st.cnt == TMW_MAX) begin
               next_st.tov = 1'b1;
            end
         end
      end
      // forced match: output only, no flag, counter untouched
      if (!is_pwm && force_compare_strobe_a) begin
         next_st.oc_a = oc_on_match(st.oc_a, output_action_bits_a, 1'b0, 1'b0);
      end
      if (!is_pwm && force_compare_strobe_b) begin
         next_st.oc_b = oc_on_match(st.oc_b, output_action_bits_b, 1'b0, 1'b0);
      end
      // cpu write last so it wins over any count or clear
      if (count_wr) begin
         next_st.cnt    = count_wdata;
         next_st.block  = 1'b1;
         next_st.pend_a = 1'b0;
         next_st.pend_b = 1'b0;
      end
      if (cmp_a_wr) begin
         next_st.buf_a = cmp_wdata;
         if (!is_pwm) begin
            next_st.ocr_a = cmp_wdata;
         end
      end
      if (cmp_b_wr) begin
         next_st.buf_b = cmp_wdata;
         if (!is_pwm) begin
            next_st.ocr_b = cmp_wdata;
         end
      end
      // a clear never loses a same-cycle set, even on an already set flag
      if (st.tov && !(flag_clear_wr[0] || int_serviced[0])) begin
         next_st.tov = 1'b1;
      end
      if (st.ocf_a && !(flag_clear_wr[1] || int_serviced[1])) begin
         next_st.ocf_a = 1'b1;
      end
      if (st.ocf_b && !(flag_clear_wr[2] || int_serviced[2])) begin
         next_st.ocf_b = 1'b1;
      end
   end

   // mode change touches no oc bit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st.cnt    <= TMW_COUNT_RESET;
         st.down   <= 1'b0;
         st.ocr_a  <= TMW_CMP_RESET;
         st.ocr_b  <= TMW_CMP_RESET;
         st.buf_a  <= TMW_CMP_RESET;
         st.buf_b  <= TMW_CMP_RESET;
         st.block  <= 1'b0;
         st.pend_a <= 1'b0;
         st.pend_b <= 1'b0;
         st.tov    <= 1'b0;
         st.ocf_a  <= 1'b0;
         st.ocf_b  <= 1'b0;
         st.oc_a   <= 1'b0;
         st.oc_b   <= 1'b0;
      end else begin
         st.cnt    <= next_st.cnt;
         st.down   <= next_st.down;
         st.ocr_a  <= next_st.ocr_a;
         st.ocr_b  <= next_st.ocr_b;
         st.buf_a  <= next_st.buf_a;
         st.buf_b  <= next_st.buf_b;
         st.block  <= next_st.block;
         st.pend_a <= next_st.pend_a;
         st.pend_b <= next_st.pend_b;
         st.tov    <= next_st.tov;
         st.ocf_a  <= next_st.ocf_a;
         st.ocf_b  <= next_st.ocf_b;
         st.oc_a   <= next_st.oc_a;
         st.oc_b   <= next_st.oc_b;
      end
   end

   // cpu reads of compare show the buffer when buffered
   assign count_value     = st.cnt;
   assign compare_value_a = is_pwm ? st.buf_a : st.ocr_a;
   assign compare_value_b = is_pwm ? st.buf_b : st.ocr_b;
   assign overflow_flag   = st.tov;
   assign match_flag_a    = st.ocf_a;
   assign match_flag_b    = st.ocf_b;
   assign int_req         = int_mask & {st.ocf_b, st.ocf_a, st.tov};
   assign wave_out_a      = (output_action_bits_a != TMW_COM_NONE) ? st.oc_a : port_out_a;
   assign wave_out_b      = (output_action_bits_b != TMW_COM_NONE) ? st.oc_b : port_out_b;
   assign wave_out_a_oe   = pin_direction_bit_a;
   assign wave_out_b_oe   = pin_direction_bit_b;
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic       mclk = 1'b0;
   logic       nrst, ext_tick_pin, wave_mode_bit2, force_compare_strobe_a, force_compare_strobe_b;
   logic       count_wr, cmp_a_wr, cmp_b_wr, port_out_a, port_out_b, pin_direction_bit_a;
   logic       pin_direction_bit_b, overflow_flag, match_flag_a, match_flag_b;
   logic       wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
   logic [1:0] wave_mode_ctl_a, output_action_bits_a, output_action_bits_b;
   logic [2:0] tick_source_select, flag_clear_wr, int_serviced, int_mask, int_req;
   logic [7:0] count_wdata, cmp_wdata, count_value, compare_value_a, compare_value_b;
   integer     seed = 79;
   int         bad_count = 0;
   int         compares = 0;
   int         cyc = 0;
   tmw_timer8 tmw_timer8_inst (.mclk, .nrst, .tick_source_select, .ext_tick_pin, .wave_mode_ctl_a,
      .wave_mode_bit2, .output_action_bits_a, .output_action_bits_b, .force_compare_strobe_a,
      .force_compare_strobe_b, .count_wr, .count_wdata, .cmp_a_wr, .cmp_b_wr, .cmp_wdata,
      .flag_clear_wr, .int_serviced, .int_mask, .port_out_a, .port_out_b, .pin_direction_bit_a,
      .pin_direction_bit_b, .count_value, .compare_value_a, .compare_value_b, .overflow_flag,
      .match_flag_a, .match_flag_b, .int_req, .wave_out_a, .wave_out_a_oe, .wave_out_b, .wave_out_b_oe);
   always #4 mclk = ~mclk;
   task automatic stop_test;
      $display("bad_count=%0d compares=%0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ceiling well above the roughly 10000 cycles the sequence needs
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // trailing idle cycle keeps two writes from sharing a time step
   task automatic wr(input int w, input logic [7:0] v);
      count_wdata = v;
      cmp_wdata = v;
      count_wr = w == 0;
      cmp_a_wr = w == 1;
      cmp_b_wr = w == 2;
      step(1);
      {count_wr, cmp_a_wr, cmp_b_wr} = 3'h0;
      step(1);
   endtask
   task automatic pl(input logic [2:0] c, input logic [2:0] s);
      flag_clear_wr = c;
      int_serviced = s;
      step(1);
      {flag_clear_wr, int_serviced} = 6'h00;
      step(1);
   endtask
   task automatic wait_cnt(input logic [7:0] v);
      for (int i = 0; i < 600 && count_value !== v; i++) begin
         step(1);
      end
      chk("reach", v, count_value);
   endtask
   function automatic logic nxt(input logic [1:0] c, input logic s);
      case (c)
         2'h1: return ~s;
         2'h2: return 1'b0;
         2'h3: return 1'b1;
         default: return s;
      endcase
   endfunction
   // prescaler ratio for each divided tick select, 2 to 5
   function automatic int div_of(input int s);
      case (s)
         2: return 8;
         3: return 64;
         4: return 256;
         default: return 1024;
      endcase
   endfunction
   initial begin
      logic       st;
      logic [7:0] r, mx, top;
      logic [2:0] modes [5];
      int         n;
      modes = '{3'h2, 3'h7, 3'h5, 3'h3, 3'h1};
      {nrst, tick_source_select, ext_tick_pin, wave_mode_ctl_a, wave_mode_bit2, output_action_bits_b} = '0;
      {force_compare_strobe_a, force_compare_strobe_b, count_wr, count_wdata, cmp_a_wr, cmp_b_wr} = '0;
      {cmp_wdata, flag_clear_wr, int_serviced, int_mask, port_out_a, port_out_b} = '0;
      {pin_direction_bit_a, pin_direction_bit_b} = 2'h0;
      output_action_bits_a = 2'h3;
      step(12);
      nrst = 1'b1;
      step(3);
      st = 1'b0;
      for (int k = 1; k < 5; k++) begin
         {port_out_a, port_out_b, pin_direction_bit_a, pin_direction_bit_b} = 4'($random(seed));
         output_action_bits_a = 2'(k);
         output_action_bits_b = 2'(k);
         {force_compare_strobe_a, force_compare_strobe_b} = 2'h3;
         step(1);
         {force_compare_strobe_a, force_compare_strobe_b} = 2'h0;
         step(1);
         st = nxt(2'(k), st);
         chk("wave_a", (k == 4) ? port_out_a : st, wave_out_a);
         chk("wave_b", (k == 4) ? port_out_b : st, wave_out_b);
      end
      chk("flags", 8'h00, 8'({overflow_flag, match_flag_a, match_flag_b}));
      output_action_bits_a = 2'h2;
      {wave_mode_bit2, wave_mode_ctl_a} = 3'h3;
      step(2);
      chk("wave_keep", st, wave_out_a);
      {wave_mode_bit2, wave_mode_ctl_a} = 3'h0;
      r = 8'($random(seed));
      wr(1, r);
      wr(0, r);
      tick_source_select = 3'h1;
      step(6);
      tick_source_select = 3'h0;
      step(3);
      chk("blocked", 8'h00, 8'(match_flag_a));
      for (int ch = 0; ch < 2; ch++) begin
         r = 8'($random(seed));
         int_mask = 3'($random(seed));
         wr(ch + 1, r);
         chk("cmp_now", r, ch ? compare_value_b : compare_value_a);
         wr(0, r - 8'h05);
         tick_source_select = 3'h1;
         step(12);
         tick_source_select = 3'h0;
         step(3);
         chk("match", 8'h01, 8'(ch ? match_flag_b : match_flag_a));
         pl(ch ? 3'h0 : 3'h2, ch ? 3'h4 : 3'h0);
         chk("cleared", 8'h00, 8'(ch ? match_flag_b : match_flag_a));
      end
      pl(3'h1, 3'h0);
      wr(0, 8'hFA);
      tick_source_select = 3'h1;
      step(12);
      tick_source_select = 3'h0;
      step(3);
      chk("ovf", 8'h01, 8'(overflow_flag));
      pl(3'h0, 3'h1);
      chk("ovf_clr", 8'h00, 8'(overflow_flag));
      for (int s = 6; s < 8; s++) begin
         n = 1 + ($random(seed) & 7);
         wr(0, 8'h00);
         tick_source_select = 3'(s);
         repeat (n) begin
            ext_tick_pin = 1'b1;
            step(3);
            ext_tick_pin = 1'b0;
            step(3);
         end
         tick_source_select = 3'h0;
         step(3);
         chk("ext", 8'(n), count_value);
      end
      // four prescaler periods of each divided select, 2 to 5, give four ticks
      for (int s = 2; s < 6; s++) begin
         wr(0, 8'h00);
         tick_source_select = 3'(s);
         step(4 * div_of(s));
         tick_source_select = 3'h0;
         step(3);
         chk("presc", 8'h04, count_value);
      end
      foreach (modes[i]) begin
         top = (modes[i] inside {3'h3, 3'h1}) ? 8'hFF : 8'h10 + 8'($random(seed) & 31);
         {wave_mode_bit2, wave_mode_ctl_a} = 3'h0;
         wr(1, top);
         {wave_mode_bit2, wave_mode_ctl_a} = modes[i];
         wr(0, 8'h00);
         tick_source_select = 3'h1;
         mx = 8'h00;
         repeat (800) begin
            step(1);
            if (count_value > mx) mx = count_value;
         end
         tick_source_select = 3'h0;
         step(3);
         chk("top", top, mx);
      end
      {wave_mode_bit2, wave_mode_ctl_a} = 3'h0;
      wr(1, 8'h40);
      {wave_mode_bit2, wave_mode_ctl_a} = 3'h3;
      wr(1, 8'h20);
      chk("cmp_buf", 8'h20, compare_value_a);
      wr(0, 8'h10);
      pl(3'h2, 3'h0);
      tick_source_select = 3'h1;
      wait_cnt(8'h30);
      chk("early", 8'h00, 8'(match_flag_a));
      wait_cnt(8'h10);
      pl(3'h2, 3'h0);
      wait_cnt(8'h30);
      chk("late", 8'h01, 8'(match_flag_a));
      tick_source_select = 3'h0;
      step(3);
      stop_test();
   end
endmodule
bind tmw_timer8 tmw_timer8_chk tmw_timer8_chk_inst (.mclk, .nrst, .tick_source_select, .wave_mode_ctl_a,
   .wave_mode_bit2, .output_action_bits_a, .force_compare_strobe_a, .count_wr, .count_wdata, .cmp_a_wr,
   .flag_clear_wr, .int_serviced, .int_mask, .port_out_a, .pin_direction_bit_a, .pin_direction_bit_b,
   .count_value, .compare_value_a, .overflow_flag, .match_flag_a, .match_flag_b, .int_req, .wave_out_a,
   .wave_out_a_oe, .wave_out_b_oe);
`default_nettype wire

// *** testbench/tmw_timer8_props.sv ***
`default_nettype none
module tmw_timer8_chk
   import tmw_pkg::*;
(
   input wire logic       mclk,
   input wire logic       nrst,
   input wire logic [2:0] tick_source_select,
   input wire logic [1:0] wave_mode_ctl_a,
   input wire logic       wave_mode_bit2,
   input wire logic [1:0] output_action_bits_a,
   input wire logic       force_compare_strobe_a,
   input wire logic       count_wr,
   input wire logic [7:0] count_wdata,
   input wire logic       cmp_a_wr,
   input wire logic [2:0] flag_clear_wr,
   input wire logic [2:0] int_serviced,
   input wire logic [2:0] int_mask,
   input wire logic       port_out_a,
   input wire logic       pin_direction_bit_a,
   input wire logic       pin_direction_bit_b,
   input wire logic [7:0] count_value,
   input wire logic [7:0] compare_value_a,
   input wire logic       overflow_flag,
   input wire logic       match_flag_a,
   input wire logic       match_flag_b,
   input wire logic [2:0] int_req,
   input wire logic       wave_out_a,
   input wire logic       wave_out_a_oe,
   input wire logic       wave_out_b_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] run_n;
   logic [1:0] stop_n;
   logic       wr_d;
   logic [2:0] mode;
   logic       run;
   logic       stopped;
   assign mode = {wave_mode_bit2, wave_mode_ctl_a};
   assign run = run_n == 2'h3 && tick_source_select == 3'h1;
   assign stopped = stop_n == 2'h3 && tick_source_select == 3'h0;
   // settle counts hide the tick select pipeline after a source change
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         run_n <= 2'h0;
         stop_n <= 2'h0;
         wr_d <= 1'b0;
      end else begin
         run_n <= (tick_source_select != 3'h1) ? 2'h0 : run_n + {1'b0, run_n != 2'h3};
         stop_n <= (tick_source_select != 3'h0) ? 2'h0 : stop_n + {1'b0, stop_n != 2'h3};
         wr_d <= count_wr;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_stop_hold: assert property (stopped && !count_wr |=> $stable(count_value))
      else $error("count moved while stopped");
   a_write_wins: assert property (count_wr |=> count_value == $past(count_wdata))
      else $error("count write lost");
   a_count_up: assert property (
      run && mode == 3'h0 && !count_wr |=> count_value == $past(count_value) + 8'h01)
      else $error("normal count step wrong");
   a_ovf_set: assert property (
      run && mode == 3'h0 && count_value == 8'hFF && !count_wr |=> ##[0:1] overflow_flag)
      else $error("overflow flag not set");
   a_ctc_clear: assert property (
      run && mode == 3'h2 && !wr_d && !count_wr && count_value == compare_value_a
      |=> count_value == 8'h00 ##[0:1] match_flag_a)
      else $error("clear on match missing");
   a_block_match: assert property (
      count_wr && mode == 3'h0 && !cmp_a_wr && !match_flag_a && count_wdata == compare_value_a
      |=> (!match_flag_a) [*3])
      else $error("match after count write");
   a_force_out: assert property (
      stopped && mode == 3'h0 && force_compare_strobe_a && output_action_bits_a == 2'h1
      && flag_clear_wr == 3'h0 && int_serviced == 3'h0
      |=> wave_out_a != $past(wave_out_a) && match_flag_a == $past(match_flag_a))
      else $error("force toggle wrong");
   a_int_req: assert property (int_req == ({match_flag_b, match_flag_a, overflow_flag} & int_mask))
      else $error("interrupt request wrong");
   a_pin_route: assert property (output_action_bits_a == 2'h0 |-> wave_out_a == port_out_a)
      else $error("port value not routed");
   a_pin_dir: assert property (
      wave_out_a_oe == pin_direction_bit_a && wave_out_b_oe == pin_direction_bit_b)
      else $error("pin direction wrong");
   a_reset_zero: assert property (
      disable iff (1'b0) !nrst && output_action_bits_a != 2'h0 |-> !wave_out_a)
      else $error("output state not reset");
endmodule
`default_nettype wire
